/* File: shared/gate_ctrl_pkg.sv */
package gate_ctrl_pkg;

	////////////////////////////////////////////////////////////////////////
	// Addressing
	localparam logic [31:0] SYS_CTRL_BASE        = 32'h400F_E000;
	localparam int          ADDR_W               = 12;
	localparam logic [11:0] RUN_GATE_OFFSET      = 12'h104;
	localparam logic [11:0] SLEEP_GATE_OFFSET    = 12'h114;
	localparam logic [11:0] DEEP_GATE_OFFSET     = 12'h124;
	localparam logic [11:0] RUN_CLOCK_CFG_OFFSET = 12'h1F0;
	localparam logic [11:0] GATE_STATUS_OFFSET   = 12'h1F4;

	////////////////////////////////////////////////////////////////////////
	// Gate bit positions
	localparam int COMPARATOR_TWO_GATE   = 26;
	localparam int COMPARATOR_ONE_GATE   = 25;
	localparam int COMPARATOR_ZERO_GATE  = 24;
	localparam int GP_COUNTER_THREE_GATE = 19;
	localparam int GP_COUNTER_TWO_GATE   = 18;
	localparam int GP_COUNTER_ONE_GATE   = 17;
	localparam int GP_COUNTER_ZERO_GATE  = 16;
	localparam int TWO_WIRE_CTRL_GATE    = 12;
	localparam int SYNC_SERIAL_ONE_GATE  = 5;
	localparam int SYNC_SERIAL_ZERO_GATE = 4;
	localparam int ASYNC_SERIAL_TWO_GATE = 2;
	localparam int ASYNC_SERIAL_ONE_GATE = 1;
	localparam int ASYNC_SERIAL_ZERO_GATE = 0;

	// Implemented gate bits; all others read zero
	localparam logic [31:0] GATE_IMPL_MASK =
		(32'h0000_0001 << COMPARATOR_TWO_GATE)   | (32'h0000_0001 << COMPARATOR_ONE_GATE)  |
		(32'h0000_0001 << COMPARATOR_ZERO_GATE)  | (32'h0000_0001 << GP_COUNTER_THREE_GATE) |
		(32'h0000_0001 << GP_COUNTER_TWO_GATE)   | (32'h0000_0001 << GP_COUNTER_ONE_GATE)  |
		(32'h0000_0001 << GP_COUNTER_ZERO_GATE)  | (32'h0000_0001 << TWO_WIRE_CTRL_GATE)   |
		(32'h0000_0001 << SYNC_SERIAL_ONE_GATE)  | (32'h0000_0001 << SYNC_SERIAL_ZERO_GATE) |
		(32'h0000_0001 << ASYNC_SERIAL_TWO_GATE) | (32'h0000_0001 << ASYNC_SERIAL_ONE_GATE) |
		(32'h0000_0001 << ASYNC_SERIAL_ZERO_GATE);

	////////////////////////////////////////////////////////////////////////
	// Reset values and configuration fields
	localparam logic [31:0] GATE_RESET             = 32'h0000_0000;
	localparam logic        AUTO_GATING_RESET      = 1'h0;
	localparam int          AUTO_CLOCK_GATING_BIT  = 0;
	localparam int          POWER_STATE_LSB        = 4;

	////////////////////////////////////////////////////////////////////////
	// Bus responses and power states
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		PWR_RUN   = 3'h1,
		PWR_SLEEP = 3'h2,
		PWR_DEEP  = 3'h4
	} power_state_t;

endpackage

/* File: shared/gate_reg_if.sv */
`timescale 1ns/10ps
interface gate_reg_if;
	logic        wr_en;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic [31:0] value;

	modport owner (input wr_en, input wr_data, input wr_strb, output value);
	modport user  (output wr_en, output wr_data, output wr_strb, input value);
endinterface

/* File: design/gate_register.sv */
`timescale 1ns/10ps
module gate_register #(
	parameter logic [31:0] RESET_VALUE = gate_ctrl_pkg::GATE_RESET,
	parameter logic [31:0] IMPL_MASK   = gate_ctrl_pkg::GATE_IMPL_MASK
) (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic reset_n_in,
	// Register access
	gate_reg_if.owner port_if
);

	logic [31:0] value_ff;
	logic [31:0] byte_mask;
	logic [31:0] nxt_value;

	assign byte_mask = {{8{port_if.wr_strb[3]}}, {8{port_if.wr_strb[2]}},
		{8{port_if.wr_strb[1]}}, {8{port_if.wr_strb[0]}}};
	// Reserved bits never store
	assign nxt_value = port_if.wr_en ?
		(((value_ff & ~byte_mask) | (port_if.wr_data & byte_mask)) & IMPL_MASK) :
		value_ff;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			value_ff <= RESET_VALUE;
		end else begin
			value_ff <= nxt_value;
		end
	end

	assign port_if.value = value_ff;

	chk_reserved_zero: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(value_ff & ~IMPL_MASK) == 32'h0000_0000)
		else $error("reserved gate bits hold a one");

endmodule

/* File: design/sleep_mode_peripheral_clock_gate.sv */
`timescale 1ns/10ps
// What this block does
// - Each implemented gate bit enables one unit clock; clear means unclocked.
// - Access to a unit whose clock is gated off answers with bus fault.
// - Reset clears every gate bit; register reads all zeros.
// - Sleep gate register decodes at offset 0x114 of system control base.
// - Separate run, sleep and deep-sleep gate registers for the same units.
// - Sleep gating applies only when auto clock gating bit is set.
// - Bits 26..24 gate comparators 2..0.
// - Bits 19..16 gate general-purpose counters 3..0.
// - Bit 12 gates the two-wire serial controller.
// - Bits 5 and 4 gate synchronous serial ports 1 and 0.
// - Bits 2..0 gate asynchronous serial ports 2..0.
// - Reserved bits are read-only zero; software preserves them.
module sleep_mode_peripheral_clock_gate (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        reset_n_in,
	// AXI4-Lite write address
	input  wire logic [11:0] s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	// AXI4-Lite read address
	input  wire logic [11:0] s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	// Power state from the core
	input  wire logic        sleep_in,
	input  wire logic        deep_sleep_in,
	// Peripheral access check
	input  wire logic        unit_access_valid_in,
	input  wire logic [4:0]  unit_access_sel_in,
	output logic             bus_fault_out,
	// Unit clock enables
	output logic [31:0]      unit_clock_enable_out
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic        aw_held_ff;
	logic        w_held_ff;
	logic        awready_ff;
	logic        wready_ff;
	logic [11:0] aw_addr_ff;
	logic [31:0] w_data_ff;
	logic [3:0]  w_strb_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        arready_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;
	logic        acg_ff;
	logic        bus_fault_ff;
	logic [31:0] enable_ff;

	gate_ctrl_pkg::power_state_t state_ff;
	gate_ctrl_pkg::power_state_t nxt_state;

	logic        aw_hs;
	logic        w_hs;
	logic        ar_hs;
	logic        do_write;
	logic        nxt_aw_held;
	logic        nxt_w_held;
	logic        nxt_bvalid;
	logic        nxt_rvalid;
	logic        wr_run;
	logic        wr_sleep;
	logic        wr_deep;
	logic        wr_cfg;
	logic        wr_mapped;
	logic        rd_mapped;
	logic [31:0] rd_data;
	logic [31:0] cfg_view;
	logic [31:0] nxt_enable;
	logic        nxt_fault;

	gate_reg_if run_if ();
	gate_reg_if sleep_if ();
	gate_reg_if deep_if ();

	////////////////////////////////////////////////////////////////////////
	// Write channels, taken in either order
	assign aw_hs       = s_axi_awvalid_in & awready_ff;
	assign w_hs        = s_axi_wvalid_in & wready_ff;
	assign do_write    = aw_held_ff & w_held_ff & ~bvalid_ff;
	assign nxt_aw_held = do_write ? 1'b0 : (aw_held_ff | aw_hs);
	assign nxt_w_held  = do_write ? 1'b0 : (w_held_ff | w_hs);
	assign nxt_bvalid  = do_write ? 1'b1 : (bvalid_ff & ~s_axi_bready_in);

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
		end else begin
			aw_held_ff <= nxt_aw_held;
			w_held_ff  <= nxt_w_held;
			awready_ff <= ~nxt_aw_held;
			wready_ff  <= ~nxt_w_held;
			bvalid_ff  <= nxt_bvalid;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			aw_addr_ff <= 12'h000;
			w_data_ff  <= 32'h0000_0000;
			w_strb_ff  <= 4'h0;
			bresp_ff   <= gate_ctrl_pkg::RESP_OKAY;
		end else begin
			if (aw_hs) begin
				aw_addr_ff <= s_axi_awaddr_in;
			end
			if (w_hs) begin
				w_data_ff <= s_axi_wdata_in;
				w_strb_ff <= s_axi_wstrb_in;
			end
			if (do_write) begin
				bresp_ff <= wr_mapped ? gate_ctrl_pkg::RESP_OKAY : gate_ctrl_pkg::RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write decode
	assign wr_run    = do_write & (aw_addr_ff == gate_ctrl_pkg::RUN_GATE_OFFSET);
	assign wr_sleep  = do_write & (aw_addr_ff == gate_ctrl_pkg::SLEEP_GATE_OFFSET);
	assign wr_deep   = do_write & (aw_addr_ff == gate_ctrl_pkg::DEEP_GATE_OFFSET);
	assign wr_cfg    = do_write & (aw_addr_ff == gate_ctrl_pkg::RUN_CLOCK_CFG_OFFSET);
	// Status register is read-only but answers OKAY
	assign wr_mapped = wr_run | wr_sleep | wr_deep | wr_cfg |
		(aw_addr_ff == gate_ctrl_pkg::GATE_STATUS_OFFSET);

	assign run_if.wr_en     = wr_run;
	assign run_if.wr_data   = w_data_ff;
	assign run_if.wr_strb   = w_strb_ff;
	assign sleep_if.wr_en   = wr_sleep;
	assign sleep_if.wr_data = w_data_ff;
	assign sleep_if.wr_strb = w_strb_ff;
	assign deep_if.wr_en    = wr_deep;
	assign deep_if.wr_data  = w_data_ff;
	assign deep_if.wr_strb  = w_strb_ff;

	// Three gate registers for the same units
	gate_register #(
		.RESET_VALUE (gate_ctrl_pkg::GATE_RESET),
		.IMPL_MASK   (gate_ctrl_pkg::GATE_IMPL_MASK)
	) u_run_gate (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.port_if    (run_if.owner)
	);

	gate_register #(
		.RESET_VALUE (gate_ctrl_pkg::GATE_RESET),
		.IMPL_MASK   (gate_ctrl_pkg::GATE_IMPL_MASK)
	) u_sleep_gate (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.port_if    (sleep_if.owner)
	);

	gate_register #(
		.RESET_VALUE (gate_ctrl_pkg::GATE_RESET),
		.IMPL_MASK   (gate_ctrl_pkg::GATE_IMPL_MASK)
	) u_deep_gate (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.port_if    (deep_if.owner)
	);

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			acg_ff <= gate_ctrl_pkg::AUTO_GATING_RESET;
		end else if (wr_cfg && w_strb_ff[0]) begin
			acg_ff <= w_data_ff[gate_ctrl_pkg::AUTO_CLOCK_GATING_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read channel
	assign ar_hs      = s_axi_arvalid_in & arready_ff;
	assign nxt_rvalid = ar_hs ? 1'b1 : (rvalid_ff & ~s_axi_rready_in);
	assign cfg_view   = (32'({acg_ff}) << gate_ctrl_pkg::AUTO_CLOCK_GATING_BIT) |
		(32'(state_ff) << gate_ctrl_pkg::POWER_STATE_LSB);
	assign rd_mapped  = (s_axi_araddr_in == gate_ctrl_pkg::RUN_GATE_OFFSET) |
		(s_axi_araddr_in == gate_ctrl_pkg::SLEEP_GATE_OFFSET) |
		(s_axi_araddr_in == gate_ctrl_pkg::DEEP_GATE_OFFSET) |
		(s_axi_araddr_in == gate_ctrl_pkg::RUN_CLOCK_CFG_OFFSET) |
		(s_axi_araddr_in == gate_ctrl_pkg::GATE_STATUS_OFFSET);
	assign rd_data =
		(s_axi_araddr_in == gate_ctrl_pkg::RUN_GATE_OFFSET)      ? run_if.value :
		(s_axi_araddr_in == gate_ctrl_pkg::SLEEP_GATE_OFFSET)    ? sleep_if.value :
		(s_axi_araddr_in == gate_ctrl_pkg::DEEP_GATE_OFFSET)     ? deep_if.value :
		(s_axi_araddr_in == gate_ctrl_pkg::RUN_CLOCK_CFG_OFFSET) ? cfg_view :
		(s_axi_araddr_in == gate_ctrl_pkg::GATE_STATUS_OFFSET)   ? enable_ff :
		32'h0000_0000;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0000_0000;
			rresp_ff   <= gate_ctrl_pkg::RESP_OKAY;
		end else begin
			arready_ff <= ~nxt_rvalid;
			rvalid_ff  <= nxt_rvalid;
			if (ar_hs) begin
				rdata_ff <= rd_data;
				rresp_ff <= rd_mapped ? gate_ctrl_pkg::RESP_OKAY : gate_ctrl_pkg::RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power state and gate selection
	assign nxt_state = deep_sleep_in ? gate_ctrl_pkg::PWR_DEEP :
		sleep_in ? gate_ctrl_pkg::PWR_SLEEP : gate_ctrl_pkg::PWR_RUN;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_ff <= gate_ctrl_pkg::PWR_RUN;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Without auto gating the run settings stay in force
	always_comb begin
		unique case (state_ff)
			gate_ctrl_pkg::PWR_RUN: begin
				nxt_enable = run_if.value;
			end
			gate_ctrl_pkg::PWR_SLEEP: begin
				nxt_enable = acg_ff ? sleep_if.value : run_if.value;
			end
			gate_ctrl_pkg::PWR_DEEP: begin
				nxt_enable = acg_ff ? deep_if.value : run_if.value;
			end
			default: begin
				nxt_enable = run_if.value;
			end
		endcase
	end

	// Fault judged against the enable the unit really sees
	assign nxt_fault = unit_access_valid_in & ~enable_ff[unit_access_sel_in];

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			enable_ff    <= gate_ctrl_pkg::GATE_RESET;
			bus_fault_ff <= 1'b0;
		end else begin
			enable_ff    <= nxt_enable;
			bus_fault_ff <= nxt_fault;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign s_axi_awready_out     = awready_ff;
	assign s_axi_wready_out      = wready_ff;
	assign s_axi_bvalid_out      = bvalid_ff;
	assign s_axi_bresp_out       = bresp_ff;
	assign s_axi_arready_out     = arready_ff;
	assign s_axi_rvalid_out      = rvalid_ff;
	assign s_axi_rdata_out       = rdata_ff;
	assign s_axi_rresp_out       = rresp_ff;
	assign bus_fault_out         = bus_fault_ff;
	assign unit_clock_enable_out = enable_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	sequence s_sleep_fire;
		do_write && (aw_addr_ff == gate_ctrl_pkg::SLEEP_GATE_OFFSET) && (w_strb_ff == 4'hF);
	endsequence

	sequence s_sleep_read;
		ar_hs && (s_axi_araddr_in == gate_ctrl_pkg::SLEEP_GATE_OFFSET);
	endsequence

	chk_reset_clear: assert property ($rose(reset_n_in) |->
		(sleep_if.value == 32'h0000_0000) && (unit_clock_enable_out == 32'h0000_0000))
		else $error("gates not clear after reset");

	chk_sleep_write: assert property (s_sleep_fire |=>
		(sleep_if.value == ($past(w_data_ff) & gate_ctrl_pkg::GATE_IMPL_MASK)) &&
		s_axi_bvalid_out && (s_axi_bresp_out == gate_ctrl_pkg::RESP_OKAY))
		else $error("sleep gate write not taken");

	chk_sleep_readback: assert property (s_sleep_read |=>
		s_axi_rvalid_out && (s_axi_rdata_out == $past(sleep_if.value)))
		else $error("sleep gate read back wrong");

	chk_run_apply: assert property ((state_ff == gate_ctrl_pkg::PWR_RUN) |=>
		unit_clock_enable_out == $past(run_if.value))
		else $error("run gates not applied");

	chk_sleep_apply: assert property ((state_ff == gate_ctrl_pkg::PWR_SLEEP) && acg_ff |=>
		unit_clock_enable_out == $past(sleep_if.value))
		else $error("sleep gates not applied");

	chk_sleep_bypass: assert property ((state_ff == gate_ctrl_pkg::PWR_SLEEP) && !acg_ff |=>
		unit_clock_enable_out == $past(run_if.value))
		else $error("sleep gates used without auto gating");

	chk_deep_apply: assert property ((state_ff == gate_ctrl_pkg::PWR_DEEP) && acg_ff |=>
		unit_clock_enable_out == $past(deep_if.value))
		else $error("deep sleep gates not applied");

	chk_gated_fault: assert property (unit_access_valid_in &&
		!unit_clock_enable_out[unit_access_sel_in] |=> bus_fault_out)
		else $error("gated unit access without fault");

	chk_open_access: assert property (unit_access_valid_in &&
		unit_clock_enable_out[unit_access_sel_in] |=> !bus_fault_out)
		else $error("clocked unit access faulted");

	chk_resp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
		s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped early");

endmodule

/* File: testbench/tb.sv */
`timescale 1ns/10ps
module tb;
	////////////////////////////////////////////////////////////////////////
	// Design ports
	logic        clk_in;
	logic        reset_n_in;
	logic [11:0] awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [11:0] araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic        sleep_in;
	logic        deep_sleep_in;
	logic        acc_valid;
	logic [4:0]  acc_sel;
	logic        bus_fault;
	logic [31:0] enables;
	int          bad_count;
	int          samples_checked;
	int          cycles = 0;
	logic [31:0] exp_en;

	sleep_mode_peripheral_clock_gate dut_u (
		.clk_in                (clk_in),
		.reset_n_in            (reset_n_in),
		.s_axi_awaddr_in       (awaddr),
		.s_axi_awvalid_in      (awvalid),
		.s_axi_awready_out     (awready),
		.s_axi_wdata_in        (wdata),
		.s_axi_wstrb_in        (wstrb),
		.s_axi_wvalid_in       (wvalid),
		.s_axi_wready_out      (wready),
		.s_axi_bresp_out       (bresp),
		.s_axi_bvalid_out      (bvalid),
		.s_axi_bready_in       (bready),
		.s_axi_araddr_in       (araddr),
		.s_axi_arvalid_in      (arvalid),
		.s_axi_arready_out     (arready),
		.s_axi_rdata_out       (rdata),
		.s_axi_rresp_out       (rresp),
		.s_axi_rvalid_out      (rvalid),
		.s_axi_rready_in       (rready),
		.sleep_in              (sleep_in),
		.deep_sleep_in         (deep_sleep_in),
		.unit_access_valid_in  (acc_valid),
		.unit_access_sel_in    (acc_sel),
		.bus_fault_out         (bus_fault),
		.unit_clock_enable_out (enables)
	);

	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			bad_count = bad_count + 1;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Tasks
	task automatic print_verdict();
		if (bad_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_in);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
			input logic [1:0] exp_resp);
		logic aw_open;
		logic w_open;
		logic ta;
		logic tw;
		@(posedge clk_in);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		aw_open = 1'b1;
		w_open  = 1'b1;
		while (aw_open || w_open) begin
			@(negedge clk_in);
			ta = aw_open && (awready === 1'b1);
			tw = w_open && (wready === 1'b1);
			@(posedge clk_in);
			if (ta) begin
				awvalid <= 1'b0;
				aw_open = 1'b0;
			end
			if (tw) begin
				wvalid <= 1'b0;
				w_open = 1'b0;
			end
		end
		do @(negedge clk_in); while (bvalid !== 1'b1);
		check({30'h0, bresp}, {30'h0, exp_resp});
		// Late bready makes the response stand one extra cycle
		@(posedge clk_in);
		bready <= 1'b1;
		@(posedge clk_in);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp_d,
			input logic [1:0] exp_resp);
		@(posedge clk_in);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(negedge clk_in); while (arready !== 1'b1);
		@(posedge clk_in);
		arvalid <= 1'b0;
		do @(negedge clk_in); while (rvalid !== 1'b1);
		check(rdata, exp_d);
		check({30'h0, rresp}, {30'h0, exp_resp});
		@(posedge clk_in);
		rready <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		bad_count = 0;
		samples_checked = 0;
		reset_n_in = 1'b0;
		awaddr = 12'h000;
		awvalid = 1'b0;
		wdata = 32'h0000_0000;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 12'h000;
		arvalid = 1'b0;
		rready = 1'b0;
		sleep_in = 1'b0;
		deep_sleep_in = 1'b0;
		acc_valid = 1'b0;
		acc_sel = 5'h00;
		wait_n(10);
		reset_n_in <= 1'b1;
		wait_n(2);
		check(enables, 32'h0000_0000);
		rd(12'h114, 32'h0000_0000, 2'h0);
		rd(12'h104, 32'h0000_0000, 2'h0);
		rd(12'h124, 32'h0000_0000, 2'h0);
		wr(12'h114, 32'hFFFF_FFFF, 4'hF, 2'h0);
		rd(12'h114, 32'h070F_1037, 2'h0);
		wr(12'h114, 32'h0000_0000, 4'h1, 2'h0);
		rd(12'h114, 32'h070F_1000, 2'h0);
		wr(12'h118, 32'hFFFF_FFFF, 4'hF, 2'h2);
		rd(12'h118, 32'h0000_0000, 2'h2);
		// Sleep without auto gating keeps the run setting
		sleep_in <= 1'b1;
		wait_n(3);
		check(enables, 32'h0000_0000);
		wr(12'h1F0, 32'h0000_0001, 4'hF, 2'h0);
		wait_n(3);
		exp_en = 32'h070F_1000;
		check(enables, exp_en);
		rd(12'h1F4, exp_en, 2'h0);
		rd(12'h1F0, 32'h0000_0021, 2'h0);
		// Every unit index, gated and ungated
		for (int i = 0; i < 32; i++) begin
			@(posedge clk_in);
			acc_valid <= 1'b1;
			acc_sel   <= 5'(i);
			@(posedge clk_in);
			acc_valid <= 1'b0;
			#1;
			check({31'h0, bus_fault}, {31'h0, ~exp_en[i]});
		end
		wr(12'h104, 32'h0000_0001, 4'hF, 2'h0);
		wr(12'h124, 32'h0001_0000, 4'hF, 2'h0);
		wait_n(3);
		check(enables, exp_en);
		sleep_in <= 1'b0;
		wait_n(3);
		check(enables, 32'h0000_0001);
		deep_sleep_in <= 1'b1;
		wait_n(3);
		check(enables, 32'h0001_0000);
		// Reset in mid-run clears everything again
		reset_n_in <= 1'b0;
		wait_n(2);
		check(enables, 32'h0000_0000);
		reset_n_in <= 1'b1;
		wait_n(2);
		rd(12'h114, 32'h0000_0000, 2'h0);
		rd(12'h1F0, 32'h0000_0040, 2'h0);
		print_verdict();
	end
endmodule
